// ==== mdm_params.svh ====
// Constants for the multiply/divide/accumulate coprocessor.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef MDM_PARAMS_SVH
`define MDM_PARAMS_SVH

// Operation codes, low nibble of the mode value
`define MDM_OP_CLR    4'h0
`define MDM_OP_AUG    4'h1
`define MDM_OP_LD0    4'h2
`define MDM_OP_READ   4'h3
`define MDM_OP_MULU   4'h4
`define MDM_OP_MULS   4'h5
`define MDM_OP_MACU   4'h6
`define MDM_OP_MACS   4'h7
`define MDM_OP_DIVU   4'h8
`define MDM_OP_DIVS   4'h9
`define MDM_OP_LD1    4'ha

// Output selects, mode bits 6:4
`define MDM_OUT_R0_LO 3'h0
`define MDM_OUT_R0_HI 3'h1
`define MDM_OUT_R1_LO 3'h2
`define MDM_OUT_R1_HI 3'h3

// Mode field layout and reset values
`define MDM_MODE_W    7
`define MDM_OPC_MSB   3
`define MDM_OSEL_LSB  4
`define MDM_MODE_RST  7'h00
`define MDM_WORD_RST  32'h0000_0000

// Divider timing: two quotient bits per cycle
`define MDM_DIV_STEPS 5'h10
`define MDM_DIV_LAT   17

`endif

// ==== mdm_pkg.sv ====
// Types shared by the coprocessor modules.
// Assumes mdm_params.svh is reachable on the include path.
`include "mdm_params.svh"

package mdm_pkg;
  // Sequencer states, one-hot
  typedef enum logic [1:0] {
    MDM_IDLE = 2'b01,
    MDM_DIV  = 2'b10
  } mdm_state_e;

  // One result register
  typedef logic [31:0] mdm_word_t;
endpackage : mdm_pkg

// ==== mdm_div.sv ====
// Iterative 32/32 divider, signed or unsigned, quotient and remainder.
// Assumes start only while idle; operands are steady at the start cycle.
`timescale 1ns/100ps
`include "mdm_params.svh"

module mdm_div import mdm_pkg::*; (
  input  wire logic      clk_in,
  input  wire logic      resetn_in,
  input  wire logic      clk_en_in,
  input  wire logic      start_in,
  input  wire logic      signed_in,
  input  wire mdm_word_t dividend_in,
  input  wire mdm_word_t divisor_in,
  output logic           busy_out,
  output logic           done_out,
  output mdm_word_t      quot_out,
  output mdm_word_t      rem_out
);
  logic [4:0] cnt_q, cnt_d;      // Remaining double steps
  mdm_word_t  quo_q, quo_d;      // Quotient, dividend shifts out of it
  mdm_word_t  rem_q, rem_d;      // Partial remainder
  mdm_word_t  dvs_q, dvs_d;      // Divisor magnitude
  logic       qneg_q, qneg_d;    // Quotient sign to restore
  logic       rneg_q, rneg_d;    // Remainder follows dividend sign
  logic       busy_q, busy_d;
  logic       done_q, done_d;

  // Next-state: load magnitudes, then two restoring steps per cycle
  always_comb begin
    logic [32:0] t;
    t      = 33'h0_0000_0000;
    cnt_d  = cnt_q;
    quo_d  = quo_q;
    rem_d  = rem_q;
    dvs_d  = dvs_q;
    qneg_d = qneg_q;
    rneg_d = rneg_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (start_in && !busy_q) begin
      // Magnitudes first; zero divisor is not special-cased
      quo_d  = (signed_in && dividend_in[31]) ? -dividend_in : dividend_in;
      dvs_d  = (signed_in && divisor_in[31]) ? -divisor_in : divisor_in;
      rem_d  = `MDM_WORD_RST;
      qneg_d = signed_in && (dividend_in[31] ^ divisor_in[31]);
      rneg_d = signed_in && dividend_in[31];
      cnt_d  = `MDM_DIV_STEPS;
      busy_d = 1'b1;
    end else if (busy_q) begin
      // Two bits per cycle keeps latency at the low end of the window
      for (int i = 0; i < 2; i++) begin
        t     = {rem_d, quo_d[31]};
        quo_d = {quo_d[30:0], 1'b0};
        if (t >= {1'b0, dvs_q}) begin
          t        = t - {1'b0, dvs_q};
          quo_d[0] = 1'b1;
        end
        rem_d = t[31:0];
      end
      cnt_d = cnt_q - 5'h01;
      if (cnt_q == 5'h01) begin
        // Last step: restore signs and hand over
        quo_d  = qneg_q ? -quo_d : quo_d;
        rem_d  = rneg_q ? -rem_d : rem_d;
        busy_d = 1'b0;
        done_d = 1'b1;
      end
    end
  end

  // Registers only; frozen while the clock enable is low
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_q  <= 5'h00;
      quo_q  <= `MDM_WORD_RST;
      rem_q  <= `MDM_WORD_RST;
      dvs_q  <= `MDM_WORD_RST;
      qneg_q <= 1'b0;
      rneg_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (clk_en_in) begin
      cnt_q  <= cnt_d;
      quo_q  <= quo_d;
      rem_q  <= rem_d;
      dvs_q  <= dvs_d;
      qneg_q <= qneg_d;
      rneg_q <= rneg_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign busy_out = busy_q;
  assign done_out = done_q;
  assign quot_out = quo_q;
  assign rem_out  = rem_q;

  // Sixteen double steps, then the done flop is seen one edge later
  property p_div_lat;
    @(posedge clk_in) disable iff (!resetn_in || !clk_en_in)
      (start_in && !busy_q) |-> ##17 done_q;
  endproperty
  a_div_lat: assert property (p_div_lat) else $error("divider latency wrong");
endmodule : mdm_div

// ==== mdm_coproc.sv ====
// Multiply, multiply-accumulate and divide coprocessor beside a 16-bit core.
// Assumes the core drives strobes and operands from the same clock domain,
// and waits on busy_out before the next operand or data strobe.
`timescale 1ns/100ps
`include "mdm_params.svh"

// Functional notes
// - Codes 4/5: 16x16 product into result zero
// - Codes 6/7: product plus accumulator, flag overflow
// - Codes 8/9: 32/32 divide in 17-20 cycles
// - No overflow or zero-divisor handling in division
// - Seven-bit mode write; low nibble is operation
// - Mode bits 6:4 pick output half, 4-7 reserved
// - Code 0 clears both result registers
// - Code 1 loads augend into low half
// - Code 2 loads result zero, 0xa result one
// - Code 3 only presents the selected half
// - Multiply returns selected half, clears condition flags
// - Dividend loaded whole in one strobe via code 2, first operand high
// - Remainder kept in result one after divide
module mdm_coproc import mdm_pkg::*; (
  input  wire logic        clk_in,        // 125 MHz core clock
  input  wire logic        resetn_in,     // Async reset, active low
  input  wire logic        clk_en_in,     // Freezes all state when low
  input  wire logic        mode_wr_in,    // Mode-write instruction strobe
  input  wire logic [6:0]  mode_in,       // Mode value for the write
  input  wire logic        send_in,       // Operand-send instruction strobe
  input  wire logic        load_in,       // Data-load instruction strobe
  input  wire logic [15:0] opa_in,        // First operand, high half of 32-bit data
  input  wire logic [15:0] opb_in,        // Second operand, low half of 32-bit data
  output logic             busy_out,      // Division in progress
  output logic             done_out,      // Division results just stored
  output logic [15:0]      result_out,    // Selected result half
  output logic [3:0]       flags_out      // Condition flags C,V,Z,N
);
  logic [6:0]   mode_q, mode_d;           // Operation select register
  mdm_word_t    rslt0_q, rslt0_d;         // Result register zero
  mdm_word_t    rslt1_q, rslt1_d;         // Result register one
  logic [3:0]   flg_q, flg_d;             // Condition flags
  logic [15:0]  out_q, out_d;             // Registered coprocessor output
  logic         done_q, done_d;           // Store-complete pulse
  mdm_state_e   st_q, st_d;               // Sequencer
  logic [3:0]   opc;                      // Current operation code
  logic         cmd;                      // Accepted operand or data strobe
  logic         div_start;                // Kick to the divider
  logic         div_done;                 // Divider result ready
  mdm_word_t    div_quo;                  // Divider quotient
  mdm_word_t    div_rem;                  // Divider remainder
  logic [33:0]  prod_w;                   // Sign-extended product
  mdm_word_t    prod;                     // Product, low 32 bits
  logic [32:0]  sum_w;                    // Accumulation with carry out
  logic         mac_ovf;                  // Accumulation overflow

  assign opc = mode_q[`MDM_OPC_MSB:0];
  // Strobes during a division are ignored; the core is expected to wait
  assign cmd = (send_in || load_in) && (st_q == MDM_IDLE);
  assign div_start = cmd && ((opc == `MDM_OP_DIVU) || (opc == `MDM_OP_DIVS));

  // Single-cycle multiplier; bit 0 of the code selects signed
  assign prod_w = $signed({opc[0] & opa_in[15], opa_in})
                * $signed({opc[0] & opb_in[15], opb_in});
  assign prod   = prod_w[31:0];
  // Accumulate in the same cycle
  assign sum_w  = {1'b0, rslt0_q} + {1'b0, prod};
  // Unsigned overflow is carry out, signed is a sign mismatch
  assign mac_ovf = opc[0] ? ((rslt0_q[31] == prod[31]) && (sum_w[31] != rslt0_q[31]))
                          : sum_w[32];

  // Divider, dividend from result zero, divisor from both operands
  mdm_div mdm_div_i (
    .clk_in      (clk_in),
    .resetn_in   (resetn_in),
    .clk_en_in   (clk_en_in),
    .start_in    (div_start),
    .signed_in   (opc[0]),
    .dividend_in (rslt0_q),
    .divisor_in  ({opa_in, opb_in}),
    .busy_out    (),
    .done_out    (div_done),
    .quot_out    (div_quo),
    .rem_out     (div_rem)
  );

  // Next values of mode, results, flags and sequencer
  always_comb begin
    mode_d = mode_q;
    rslt0_d = rslt0_q;
    rslt1_d = rslt1_q;
    flg_d  = flg_q;
    st_d   = st_q;
    done_d = 1'b0;
    // Whole seven bits taken on a mode write
    if (mode_wr_in) begin
      mode_d = mode_in;
    end
    case (st_q)
      MDM_IDLE: begin
        if (cmd) begin
          case (opc)
            `MDM_OP_CLR: begin
              rslt0_d = `MDM_WORD_RST;
              rslt1_d = `MDM_WORD_RST;
            end
            // Upper half kept, only the augend lands
            `MDM_OP_AUG:  rslt0_d[15:0] = opb_in;
            // First operand high, second low
            `MDM_OP_LD0:  rslt0_d = {opa_in, opb_in};
            `MDM_OP_LD1:  rslt1_d = {opa_in, opb_in};
            // Nothing computed, only the output path is used
            `MDM_OP_READ: rslt0_d = rslt0_q;
            `MDM_OP_MULU, `MDM_OP_MULS: begin
              rslt0_d = prod;
              flg_d  = 4'h0;
            end
            `MDM_OP_MACU, `MDM_OP_MACS: begin
              rslt0_d = sum_w[31:0];
              // Carry, overflow, zero, negative
              flg_d  = {sum_w[32], mac_ovf, (sum_w[31:0] == 32'h0000_0000), sum_w[31]};
            end
            `MDM_OP_DIVU, `MDM_OP_DIVS: begin
              flg_d = 4'h0;
              st_d  = MDM_DIV;
            end
            // Reserved codes leave everything alone
            default: rslt0_d = rslt0_q;
          endcase
        end
      end
      MDM_DIV: begin
        // Quotient to result zero, remainder to result one
        if (div_done) begin
          rslt0_d = div_quo;
          rslt1_d = div_rem;
          done_d = 1'b1;
          st_d   = MDM_IDLE;
        end
      end
      default: st_d = MDM_IDLE;
    endcase
  end

  // Output half from the values being stored, so a read sees fresh data
  always_comb begin
    case (mode_d[6:`MDM_OSEL_LSB])
      `MDM_OUT_R0_LO: out_d = rslt0_d[15:0];
      `MDM_OUT_R0_HI: out_d = rslt0_d[31:16];
      `MDM_OUT_R1_LO: out_d = rslt1_d[15:0];
      `MDM_OUT_R1_HI: out_d = rslt1_d[31:16];
      // Reserved selects read a fixed zero
      default:        out_d = 16'h0000;
    endcase
  end

  // State registers, held while the clock enable is low
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode_q <= `MDM_MODE_RST;
      rslt0_q <= `MDM_WORD_RST;
      rslt1_q <= `MDM_WORD_RST;
      flg_q  <= 4'h0;
      out_q  <= 16'h0000;
      done_q <= 1'b0;
      st_q   <= MDM_IDLE;
    end else if (clk_en_in) begin
      mode_q <= mode_d;
      rslt0_q <= rslt0_d;
      rslt1_q <= rslt1_d;
      flg_q  <= flg_d;
      out_q  <= out_d;
      done_q <= done_d;
      st_q   <= st_d;
    end
  end

  assign busy_out   = (st_q == MDM_DIV);
  assign done_out   = done_q;
  assign result_out = out_q;
  assign flags_out  = flg_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in || !clk_en_in);

  // Unsigned product lands in result zero
  property p_mulu;
    cmd && opc == `MDM_OP_MULU |=> rslt0_q == $past(opa_in) * $past(opb_in);
  endproperty
  a_mulu: assert property (p_mulu) else $error("unsigned product wrong");

  // Accumulator grows by the product
  property p_mac;
    cmd && opc == `MDM_OP_MACU |=>
      rslt0_q == $past(rslt0_q) + ($past(opa_in) * $past(opb_in));
  endproperty
  a_mac: assert property (p_mac) else $error("accumulate wrong");

  // Busy on the first eight edges after the strobe and on the 17th, results seen on the 18th
  property p_div;
    div_start |=> busy_out [*8] ##9 busy_out ##1 (done_out && !busy_out);
  endproperty
  a_div: assert property (p_div) else $error("division timing wrong");

  // Mode write is taken whole
  property p_mode;
    mode_wr_in |=> mode_q == $past(mode_in);
  endproperty
  a_mode: assert property (p_mode) else $error("mode not stored");

  // High half of result zero is presented when selected
  property p_sel;
    mode_q[6:4] == `MDM_OUT_R0_HI |-> result_out == rslt0_q[31:16];
  endproperty
  a_sel: assert property (p_sel) else $error("output select wrong");

  // Clear empties both registers
  property p_clr;
    cmd && opc == `MDM_OP_CLR |=> rslt0_q == 32'h0000_0000 && rslt1_q == 32'h0000_0000;
  endproperty
  a_clr: assert property (p_clr) else $error("clear failed");

  // Augend fills low half only
  property p_aug;
    cmd && opc == `MDM_OP_AUG |=>
      rslt0_q == {$past(rslt0_q[31:16]), $past(opb_in)};
  endproperty
  a_aug: assert property (p_aug) else $error("augend load wrong");

  // Data load into result one
  property p_ld1;
    cmd && opc == `MDM_OP_LD1 |=> rslt1_q == {$past(opa_in), $past(opb_in)};
  endproperty
  a_ld1: assert property (p_ld1) else $error("result one load wrong");

  // Read and reserved codes leave both registers stable
  property p_hold;
    cmd && (opc == `MDM_OP_READ || opc > `MDM_OP_LD1) |=>
      $stable(rslt0_q) && $stable(rslt1_q);
  endproperty
  a_hold: assert property (p_hold) else $error("register changed");

  // Signed multiply clears the condition flags
  property p_flg;
    cmd && opc == `MDM_OP_MULS |=> flags_out == 4'h0;
  endproperty
  a_flg: assert property (p_flg) else $error("flags not cleared");
endmodule : mdm_coproc

// ==== mdm_core_model.sv ====
// Behavioural model of the 16-bit core driving the coprocessor.
// Assumes the same clock as the coprocessor; waits on busy before returning.
`timescale 1ns/100ps

module mdm_core_model (
  input  wire logic   clk_in,      // Core clock
  input  wire logic   busy_in,     // Division running
  input  wire logic   done_in,     // Division results stored
  output logic        clk_en_out,  // Run enable
  output logic        mode_wr_out, // Mode write strobe
  output logic [6:0]  mode_out,    // Mode value
  output logic        send_out,    // Operand send strobe
  output logic        load_out,    // Data load strobe
  output logic [15:0] opa_out,     // First operand, high half
  output logic [15:0] opb_out      // Second operand, low half
);
  // Idle values from time zero
  initial begin
    clk_en_out = 1'b1;
    mode_wr_out = 1'b0;
    mode_out = 7'h00;
    send_out = 1'b0;
    load_out = 1'b0;
    opa_out = 16'h0000;
    opb_out = 16'h0000;
  end

  // Run or freeze the coprocessor
  task automatic run(input logic on);
    @(posedge clk_in);
    #1;
    clk_en_out = on;
  endtask : run

  // One mode write, all seven bits at once
  task automatic mode(input logic [6:0] m);
    @(posedge clk_in);
    #1;
    mode_wr_out = 1'b1;
    mode_out = m;
    @(posedge clk_in);
    #1;
    mode_wr_out = 1'b0;
    mode_out = ~m; // Stale value must not linger
  endtask : mode

  // Operand send or data load; follows a division to its end
  task automatic cmd(input logic ld, input logic [15:0] a, input logic [15:0] b, output int n);
    @(posedge clk_in);
    #1;
    send_out = !ld;
    load_out = ld;
    opa_out = a;
    opb_out = b;
    @(posedge clk_in);
    #1;
    send_out = 1'b0;
    load_out = 1'b0;
    opa_out = ~a; // Released lines show the inverse
    opb_out = ~b;
    n = 0;
    // Bounded wait; a stray strobe mid-division has to be ignored
    while (busy_in && !done_in && n < 40) begin
      @(posedge clk_in);
      #1;
      n++;
      send_out = (n == 2);
    end
  endtask : cmd
endmodule : mdm_core_model

// ==== mdm_coproc_test.sv ====
// Self-checking bench for the multiply/divide/accumulate coprocessor.
// Assumes mdm_core_model plays the core; expected values are worked by hand.
`timescale 1ns/100ps

module mdm_coproc_test import mdm_pkg::*;;
  logic        clk_in = 1'b0;    // 125 MHz clock
  logic        resetn_in = 1'b0; // Reset, active low
  logic        clk_en_in, mode_wr_in, send_in, load_in;
  logic [6:0]  mode_in;          // Mode value
  logic [15:0] opa_in, opb_in;   // Operands
  logic        busy_out, done_out;
  logic [15:0] result_out;       // Selected half
  logic [3:0]  flags_out;        // C,V,Z,N
  int          failures = 0;     // Mismatch count
  int          tests_run = 0;    // Comparison count

  mdm_coproc mdm_coproc_i (.clk_in(clk_in), .resetn_in(resetn_in), .clk_en_in(clk_en_in),
    .mode_wr_in(mode_wr_in), .mode_in(mode_in), .send_in(send_in), .load_in(load_in),
    .opa_in(opa_in), .opb_in(opb_in), .busy_out(busy_out), .done_out(done_out),
    .result_out(result_out), .flags_out(flags_out));

  mdm_core_model mdm_core_model_i (.clk_in(clk_in), .busy_in(busy_out), .done_in(done_out),
    .clk_en_out(clk_en_in), .mode_wr_out(mode_wr_in), .mode_out(mode_in),
    .send_out(send_in), .load_out(load_in), .opa_out(opa_in), .opb_out(opb_in));

  // Clock, 8 ns period
  always #4 clk_in = ~clk_in;

  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Counts, verdict, end of run
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // Mode write then one strobe
  task automatic op(input logic [6:0] m, input logic ld, input logic [15:0] a,
                    input logic [15:0] b);
    int n;
    mdm_core_model_i.mode(m);
    mdm_core_model_i.cmd(ld, a, b, n);
  endtask : op

  // Select a half and compare it
  task automatic rd(input string what, input logic [6:0] m, input logic [15:0] exp);
    mdm_core_model_i.mode(m);
    check(what, 32'(result_out), 32'(exp));
  endtask : rd

  // Unsigned and signed products, both halves, flags cleared
  task automatic t_mul();
    logic [31:0] p [2];
    p = '{32'h0002_fffa, 32'hffff_fffa};
    for (int s = 0; s < 2; s++) begin
      op(7'h04 + 7'(s), 1'b0, 16'hfffe, 16'h0003);
      check("mul lo", 32'(result_out), 32'(p[s][15:0]));
      check("mul flags", 32'(flags_out), 32'h0);
      rd("mul hi", 7'h13, p[s][31:16]);
    end
  endtask : t_mul

  // Result one load, reserved codes and selects
  task automatic t_load();
    op(7'h3a, 1'b1, 16'hdead, 16'hbeef);
    check("ld1 hi", 32'(result_out), 32'hdead);
    rd("ld1 lo", 7'h23, 16'hbeef);
    op(7'h23, 1'b0, 16'h5555, 16'h6666);
    check("read op", 32'(result_out), 32'hbeef);
    for (int c = 11; c < 16; c++) begin
      op(7'h20 | 7'(c), 1'b0, 16'h0001, 16'h0001);
      check("reserved op", 32'(result_out), 32'hbeef);
    end
    for (int s = 4; s < 8; s++) rd("reserved sel", 7'(s << 4) | 7'h03, 16'h0000);
    rd("r1 kept", 7'h33, 16'hdead);
  endtask : t_load

  // Clear, augend, accumulate with and without overflow
  task automatic t_mac();
    op(7'h00, 1'b0, 16'h1111, 16'h2222);
    rd("clear r0", 7'h10, 16'h0000);
    rd("clear r1", 7'h30, 16'h0000);
    op(7'h01, 1'b0, 16'h5555, 16'h1234);
    check("augend", 32'(result_out), 32'h1234);
    op(7'h06, 1'b0, 16'hffff, 16'hffff);
    check("mac lo", 32'(result_out), 32'h1235);
    check("mac flags", 32'(flags_out), 32'h1);
    op(7'h06, 1'b0, 16'hffff, 16'hffff);
    check("mac ovf lo", 32'(result_out), 32'h1236);
    check("mac ovf flags", 32'(flags_out), 32'hd);
    op(7'h07, 1'b0, 16'h0002, 16'h0003);
    check("smac lo", 32'(result_out), 32'h123c);
    check("smac flags", 32'(flags_out), 32'h1);
    op(7'h04, 1'b0, 16'h0000, 16'h0000);
    check("mul flags clear", 32'(flags_out), 32'h0);
  endtask : t_mac

  // Dividend load, divide, quotient and remainder
  task automatic t_div(input logic [6:0] m, input logic [31:0] dd, input logic [31:0] dv,
                       input logic [31:0] q, input logic [31:0] r);
    int n;
    op(7'h12, 1'b1, dd[31:16], dd[15:0]);
    check("dividend", 32'(result_out), 32'(dd[31:16]));
    mdm_core_model_i.mode(m);
    mdm_core_model_i.cmd(1'b0, dv[31:16], dv[15:0], n);
    // A hung divider is counted here; the run still reaches the report
    if (n >= 40) begin
      failures++;
    end
    check("div cycles", 32'(n >= 17 && n <= 20), 32'h1);
    check("div done", 32'(done_out), 32'h1);
    check("div idle", 32'(busy_out), 32'h0);
    check("quot lo", 32'(result_out), 32'(q[15:0]));
    rd("quot hi", 7'h13, q[31:16]);
    rd("rem lo", 7'h23, r[15:0]);
    rd("rem hi", 7'h33, r[31:16]);
  endtask : t_div

  // Frozen clock enable holds mode and registers
  task automatic t_freeze();
    mdm_core_model_i.run(1'b0);
    op(7'h00, 1'b0, 16'h0000, 16'h0000);
    check("frozen", 32'(result_out), 32'hffff);
    mdm_core_model_i.run(1'b1);
    rd("after freeze", 7'h23, 16'hfffe);
  endtask : t_freeze

  // Reset, then every scenario in turn
  initial begin
    repeat (2) @(posedge clk_in);
    #1;
    check("reset outs", 32'({busy_out, done_out, flags_out, result_out}), 32'h0);
    resetn_in = 1'b1;
    t_mul();
    t_load();
    t_mac();
    t_div(7'h08, 32'd100, 32'd7, 32'd14, 32'd2);
    t_div(7'h08, 32'd5, 32'd0, 32'hffff_ffff, 32'd5);
    t_div(7'h09, 32'hffff_ff9c, 32'd7, 32'hffff_fff2, 32'hffff_fffe);
    t_freeze();
    wrap_up();
  end
endmodule : mdm_coproc_test
